// ---- dv/acsd_host_model.sv ----
// Host controller model: clocks 28-bit frames out on the serial pair.
// Assumes a 12 ns link clock that stands still between frames.
`timescale 1ns/10ps
`default_nettype none
module acsd_host_model (
    output logic serClk,
    output logic serData,
    output logic serDataHigh
);
    initial begin
        serClk = 1'b0;
        serData = 1'b0;
        serDataHigh = 1'b0;
    end
    task automatic pulse();
        #6 serClk = 1'b1;
        #6 serClk = 1'b0;
    endtask
    // Bit v[27] goes out first as D0; data moves only while the clock is low
    task automatic send(input logic [27:0] v, input int skipAt);
        for (int i = 27; i >= 0; i--) begin
            if (i == skipAt) begin
                serData = 1'b1;
                serDataHigh = 1'b1;
                pulse();
                serDataHigh = 1'b0;
            end
            serData = v[i];
            pulse();
        end
        // Released line shows the inverse so a held value cannot pass
        serData = ~v[0];
    endtask
endmodule
`default_nettype wire

// ---- dv/acsd_top_asserts.sv ----
// Checker for the decoder top: pulse and setting relations on core_clk.
// Assumes it is bound onto acsd_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module acsd_top_asserts
    import acsd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [25:0] setVec,
    input wire logic [W_VOLA-1:0] ch1Coarse,
    input wire logic [W_VOLB-1:0] ch1Fine,
    input wire logic [W_VOLA-1:0] ch2Coarse,
    input wire logic [W_VOLB-1:0] ch2Fine,
    input wire logic ch1Mute,
    input wire logic ch2Mute,
    input wire logic [6:0] ch1AttenDb,
    input wire logic [6:0] ch2AttenDb,
    input wire logic frameRejected,
    input wire logic settingsUpdated
);
    // Fine steps below -1dB are clamped above the -42dB coarse point
    function automatic logic [6:0] attenOf(input logic [4:0] c, input logic [1:0] f);
        logic [6:0] a;
        a = (c <= VOLA_42DB) ? {1'b0, c, 1'b0} : 7'h2a + {c - VOLA_42DB, 2'b00};
        return a + ((c >= VOLA_42DB || f == 2'h0) ? {5'h00, f} : 7'h01);
    endfunction
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    pulse_excl_a: assert property (!(settingsUpdated && frameRejected))
        else $error("update and reject pulses together");
    upd_pulse_a: assert property (settingsUpdated |=> !settingsUpdated)
        else $error("update pulse longer than one cycle");
    rej_keep_a: assert property (frameRejected |=> $stable(setVec) ##1 $stable(setVec))
        else $error("settings moved after a rejected frame");
    change_cause_a: assert property (!$stable(setVec) |-> settingsUpdated || $past(settingsUpdated))
        else $error("settings moved without an update");
    mute_one_a: assert property ($stable(ch1Coarse) |-> ch1Mute == (ch1Coarse == VOLA_MUTE))
        else $error("channel 1 mute wrong");
    mute_two_a: assert property ($stable(ch2Coarse) |-> ch2Mute == (ch2Coarse == VOLA_MUTE))
        else $error("channel 2 mute wrong");
    atten_one_a: assert property ($stable({ch1Coarse, ch1Fine})[*3] ##0 !ch1Mute |->
        ch1AttenDb == attenOf(ch1Coarse, ch1Fine)) else $error("channel 1 attenuation wrong");
    atten_two_a: assert property ($stable({ch2Coarse, ch2Fine})[*3] ##0 !ch2Mute |->
        ch2AttenDb == attenOf(ch2Coarse, ch2Fine)) else $error("channel 2 attenuation wrong");
    cover property (settingsUpdated);
    cover property (frameRejected);
    cover property (!ch1Mute && ch1Coarse > VOLA_42DB && ch1Fine == 2'h3);
endmodule
`default_nettype wire

// ---- dv/acsd_top_tb.sv ----
// Testbench for the decoder top: host model frames in, settings checked.
// Assumes the checker is bound below and the host model owns the link.
`timescale 1ns/10ps
`default_nettype none
module acsd_top_tb;
    import acsd_pkg::*;
    logic core_clk, rstn, serClk, serData, serDataHigh;
    logic gainSel11dB, bassBoost, trebBoost, ch1Mute, ch2Mute, frameRejected, settingsUpdated;
    logic [2:0] dynBassCode, bassMag, trebMag;
    logic [4:0] ch1Coarse, ch2Coarse;
    logic [1:0] ch1Fine, ch2Fine;
    logic [6:0] ch1AttenDb, ch2AttenDb;
    logic [25:0] setNow, lastSet;
    logic [13:0] tab [7] = '{14'h0181, 14'h0283, 14'h2bad, 14'h2d30, 14'h3ccf, 14'h3dd1,
        14'h2929};
    int miscompares = 0;
    int samplesChecked = 0;
    assign setNow = {gainSel11dB, dynBassCode, bassBoost, bassMag, trebBoost, trebMag,
        ch2Coarse, ch2Fine, ch1Coarse, ch1Fine};
    acsd_top dut (.core_clk(core_clk), .rstn(rstn), .serClk(serClk), .serData(serData),
        .serDataHigh(serDataHigh), .gainSel11dB(gainSel11dB), .dynBassCode(dynBassCode),
        .bassBoost(bassBoost), .bassMag(bassMag), .trebBoost(trebBoost), .trebMag(trebMag),
        .ch1Coarse(ch1Coarse), .ch1Fine(ch1Fine), .ch2Coarse(ch2Coarse), .ch2Fine(ch2Fine),
        .ch1Mute(ch1Mute), .ch2Mute(ch2Mute), .ch1AttenDb(ch1AttenDb), .ch2AttenDb(ch2AttenDb),
        .frameRejected(frameRejected), .settingsUpdated(settingsUpdated));
    acsd_host_model host (.serClk(serClk), .serData(serData), .serDataHigh(serDataHigh));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic printVerdict();
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Sends one frame, waits a bounded time for its pulse, then checks settings
    task automatic frame(input logic [27:0] v, input int skipAt, input logic [1:0] expPulse);
        logic [1:0] got;
        got = 2'b00;
        host.send(v, skipAt);
        for (int i = 0; i < 40 && got == 2'b00; i++) begin
            @(negedge core_clk);
            got = {settingsUpdated, frameRejected};
        end
        check("pulses", {30'h0, got}, {30'h0, expPulse});
        repeat (2) @(negedge core_clk);
        if (expPulse == 2'b10) lastSet = v[27:2];
        check("settings", {6'h00, setNow}, {6'h00, lastSet});
    endtask
    task automatic scFields();
        frame({1'b1, 3'h4, 4'hd, 4'h5, 5'h0a, 2'h1, 5'h03, 2'h0, 2'h3}, -1, 2'b10);
        frame({1'b0, 3'h1, 4'h5, 4'hd, 5'h1f, 2'h3, 5'h15, 2'h2, 2'h3}, -1, 2'b10);
        check("mutes", {30'h0, ch1Mute, ch2Mute}, 32'h0000_0001);
    endtask
    task automatic scReject();
        for (int cs = 0; cs < 3; cs++) frame({~lastSet, cs[1:0]}, -1, 2'b01);
    endtask
    task automatic scSkip();
        frame({1'b0, 3'h2, 4'h3, 4'hb, 5'h16, 2'h3, 5'h1e, 2'h1, 2'h3}, 13, 2'b10);
    endtask
    // Table rows: coarse code, fine code, expected attenuation in dB
    task automatic scAtten();
        for (int i = 0; i < 7; i++) begin
            frame({8'h00, 4'h0, tab[i][13:7], tab[i][13:7], 2'h3}, -1, 2'b10);
            check("ch1 atten", {25'h0, ch1AttenDb}, {25'h0, tab[i][6:0]});
            check("ch2 atten", {25'h0, ch2AttenDb}, {25'h0, tab[i][6:0]});
        end
    endtask
    initial begin
        rstn = 1'b0;
        lastSet = {RST_GAIN, RST_DBB, RST_TONE, RST_TONE, RST_VOLA, RST_VOLB, RST_VOLA, RST_VOLB};
        repeat (10) @(negedge core_clk);
        host.pulse();
        repeat (10) @(negedge core_clk);
        rstn = 1'b1;
        repeat (4) @(negedge core_clk);
        check("reset state", {6'h00, setNow}, {6'h00, lastSet});
        scFields();
        scReject();
        scSkip();
        scAtten();
        printVerdict();
    end
    // Watchdog well beyond the 13 frames of the run
    initial begin
        #50000;
        miscompares++;
        printVerdict();
    end
endmodule
bind acsd_top acsd_top_asserts chk (.core_clk(core_clk), .rstn(rstn),
    .setVec({gainSel11dB, dynBassCode, bassBoost, bassMag, trebBoost, trebMag,
    ch2Coarse, ch2Fine, ch1Coarse, ch1Fine}), .ch1Coarse(ch1Coarse), .ch1Fine(ch1Fine),
    .ch2Coarse(ch2Coarse), .ch2Fine(ch2Fine), .ch1Mute(ch1Mute), .ch2Mute(ch2Mute),
    .ch1AttenDb(ch1AttenDb), .ch2AttenDb(ch2AttenDb), .frameRejected(frameRejected),
    .settingsUpdated(settingsUpdated));
`default_nettype wire

// ---- hdl/acsd_frame_if.sv ----
// Carrier between the link-side shifter and the core-side decoder.
// Assumes the frame word is held stable while the toggle is in flight.
`timescale 1ns/10ps
`default_nettype none
interface acsd_frame_if;
    import acsd_pkg::*;
    logic [FRAME_BITS-1:0] frameWord;
    logic frameToggle;
    modport link (output frameWord, output frameToggle);
    modport core (input frameWord, input frameToggle);
endinterface
`default_nettype wire

// ---- hdl/acsd_link_shifter.sv ----
// Link-side shift register on the serial clock.
// Assumes the serial clock only runs during frames; a frame ends when the
// bit counter reaches CNT_LAST (27) on a sampled bit.
`timescale 1ns/10ps
`default_nettype none
module acsd_link_shifter
    import acsd_pkg::*;
(
    input wire logic serClk,
    input wire logic rstn,
    input wire logic serData,
    input wire logic serDataHigh,
    acsd_frame_if.link frameOut
);
    logic [FRAME_BITS-1:0] shiftReg;
    logic [CNT_W-1:0] cnt_reg;
    logic bitIn;
    logic [FRAME_BITS-1:0] word_reg;
    logic tog_reg;

    // High input level forces the internal data low
    assign bitIn = serData & ~serDataHigh; // RL3

    // D0 arrives first, so it shifts down to bit 0 by the end
    always_ff @(posedge serClk or negedge rstn) begin // RL2
        if (!rstn) begin
            shiftReg <= '0;
        end else if (!serDataHigh) begin // RL3
            shiftReg <= {bitIn, shiftReg[FRAME_BITS-1:1]}; // RL1
        end
    end

    always_ff @(posedge serClk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= CNT_ZERO;
        end else if (!serDataHigh) begin
            cnt_reg <= (cnt_reg == CNT_LAST) ? CNT_ZERO : cnt_reg + CNT_ONE; // RL1
        end
    end

    // Whole frame handed over at once, with the toggle as its event
    always_ff @(posedge serClk or negedge rstn) begin
        if (!rstn) begin
            word_reg <= '0;
            tog_reg <= 1'b0;
        end else if (!serDataHigh && cnt_reg == CNT_LAST) begin
            word_reg <= {bitIn, shiftReg[FRAME_BITS-1:1]}; // RL13
            tog_reg <= ~tog_reg;
        end
    end

    assign frameOut.frameWord = word_reg;
    assign frameOut.frameToggle = tog_reg;
endmodule
`default_nettype wire

// ---- hdl/acsd_pkg.sv ----
// Package for the audio control serial decoder: frame layout, field
// positions, code values and small shared types.
// Assumes a two-line serial link (clock plus data) from a host controller.
package acsd_pkg;
    localparam int FRAME_BITS = 28;
    localparam int CNT_W = 5;
    localparam int POS_GAIN = 0;
    localparam int POS_DBB = 1;
    localparam int POS_BASS = 4;
    localparam int POS_TREB = 8;
    localparam int POS_CH2A = 12;
    localparam int POS_CH2B = 17;
    localparam int POS_CH1A = 19;
    localparam int POS_CH1B = 24;
    localparam int POS_CS = 26;
    localparam int W_DBB = 3;
    localparam int W_TONE = 4;
    localparam int W_VOLA = 5;
    localparam int W_VOLB = 2;
    localparam int W_CS = 2;
    localparam logic [1:0] CS_VALID = 2'h3;
    localparam logic [2:0] DBB_MAX = 3'h4;
    localparam logic [2:0] TONE_MAG_MAX = 3'h5;
    localparam logic [4:0] VOLA_42DB = 5'h15;
    localparam logic [4:0] VOLA_MUTE = 5'h1f;
    localparam logic [1:0] VOLB_1DB = 2'h1;
    localparam logic [4:0] VOLA_MAX_ATTEN = 5'h1f;
    // Reset values: gain 14dB, flat tone, no boost, full attenuation
    localparam logic RST_GAIN = 1'b0;
    localparam logic [2:0] RST_DBB = 3'h0;
    localparam logic [3:0] RST_TONE = 4'h0;
    localparam logic [4:0] RST_VOLA = 5'h1f;
    localparam logic [1:0] RST_VOLB = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h1b;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    typedef enum logic [2:0] {
        ACSD_IDLE = 3'b001,
        ACSD_SHIFT = 3'b010,
        ACSD_DONE = 3'b100
    } acsd_state_t;
endpackage

// ---- hdl/acsd_top.sv ----
// Top of the audio control serial decoder: serial link in, decoded
// settings out as plain registered ports.
// Assumes serClk is a separate, unrelated clock from core_clk.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RL1: A frame is 28 bits, sent D0 first through D27, assembled into one word.
// RL2: Serial data is sampled on every rising edge of the serial clock.
// RL3: While the data pin is at its high level the bit is forced low and ignored.
// RL4: Settings change only if D26 and D27 are both 1, else all stay as they were.
// RL5: The chip select is fixed, so only one device sits on a controller.
// RL6: D0 picks input amp gain, 1 for 11dB and 0 for 14dB.
// RL7: D1 to D3 code dynamic bass boost from 0dB to 20dB in 5dB steps.
// RL8: D4 is bass boost or cut and D5 to D7 its magnitude up to 10.5dB.
// RL9: D8 is treble boost or cut and D9 to D11 its magnitude up to 10dB.
// RL10: Coarse volume uses D19-D23 (ch1) and D12-D16 (ch2); code 11111 mutes.
// RL11: Fine volume uses D24-D25 (ch1) and D17-D18 (ch2) for 0 to -3dB extra.
// RL12: Fine -2dB and -3dB act only at coarse -42dB or lower, giving 0 to -81dB.
// RL13: All settings update together from a complete valid frame.
module acsd_top
    import acsd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic serClk,
    input wire logic serData,
    input wire logic serDataHigh,
    output logic gainSel11dB,
    output logic [W_DBB-1:0] dynBassCode,
    output logic bassBoost,
    output logic [2:0] bassMag,
    output logic trebBoost,
    output logic [2:0] trebMag,
    output logic [W_VOLA-1:0] ch1Coarse,
    output logic [W_VOLB-1:0] ch1Fine,
    output logic [W_VOLA-1:0] ch2Coarse,
    output logic [W_VOLB-1:0] ch2Fine,
    output logic ch1Mute,
    output logic ch2Mute,
    output logic [6:0] ch1AttenDb,
    output logic [6:0] ch2AttenDb,
    output logic frameRejected,
    output logic settingsUpdated
);
    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    logic rstSync1_reg;
    logic rstSync2_reg;
    logic rstnCore;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstSync1_reg <= 1'b0;
            rstSync2_reg <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstSync2_reg <= rstSync1_reg;
        end
    end
    assign rstnCore = rstSync2_reg;

    // ---------------------------------------------------------------
    // Link side
    // ---------------------------------------------------------------
    acsd_frame_if frameBus ();

    acsd_link_shifter uShifter (
        .serClk(serClk),
        .rstn(rstn),
        .serData(serData),
        .serDataHigh(serDataHigh),
        .frameOut(frameBus.link)
    );

    // ---------------------------------------------------------------
    // Crossing: toggle through three flops, word sampled once agreed
    // ---------------------------------------------------------------
    logic togS1_reg;
    logic togS2_reg;
    logic togS3_reg;
    logic togSeen_reg;
    logic frameEvent;

    always_ff @(posedge core_clk or negedge rstnCore) begin
        if (!rstnCore) begin
            togS1_reg <= 1'b0;
            togS2_reg <= 1'b0;
            togS3_reg <= 1'b0;
        end else begin
            togS1_reg <= frameBus.frameToggle;
            togS2_reg <= togS1_reg;
            togS3_reg <= togS2_reg;
        end
    end

    // Count a change only when stages two and three agree
    always_ff @(posedge core_clk or negedge rstnCore) begin
        if (!rstnCore) begin
            togSeen_reg <= 1'b0;
        end else if (togS2_reg == togS3_reg) begin
            togSeen_reg <= togS3_reg;
        end
    end
    assign frameEvent = (togS2_reg == togS3_reg) && (togS3_reg != togSeen_reg);

    // Frame word has been stable for several core_clk edges by now
    logic [FRAME_BITS-1:0] word;
    logic csOk;
    assign word = frameBus.frameWord;
    // Fixed select, no per-device address compare
    assign csOk = (word[POS_CS +: W_CS] == CS_VALID); // RL4 RL5

    // ---------------------------------------------------------------
    // Settings registers: one update per valid frame
    // ---------------------------------------------------------------
    logic gain_reg;
    logic [W_DBB-1:0] dbb_reg;
    logic [W_TONE-1:0] bass_reg;
    logic [W_TONE-1:0] treb_reg;
    logic [W_VOLA-1:0] c1a_reg;
    logic [W_VOLB-1:0] c1b_reg;
    logic [W_VOLA-1:0] c2a_reg;
    logic [W_VOLB-1:0] c2b_reg;

    always_ff @(posedge core_clk or negedge rstnCore) begin
        if (!rstnCore) begin
            gain_reg <= RST_GAIN;
            dbb_reg <= RST_DBB;
            bass_reg <= RST_TONE;
            treb_reg <= RST_TONE;
            c1a_reg <= RST_VOLA;
            c1b_reg <= RST_VOLB;
            c2a_reg <= RST_VOLA;
            c2b_reg <= RST_VOLB;
        end else if (frameEvent && csOk) begin // RL4 RL13
            gain_reg <= word[POS_GAIN]; // RL6
            dbb_reg <= word[POS_DBB +: W_DBB]; // RL7
            bass_reg <= word[POS_BASS +: W_TONE]; // RL8
            treb_reg <= word[POS_TREB +: W_TONE]; // RL9
            c1a_reg <= word[POS_CH1A +: W_VOLA]; // RL10
            c1b_reg <= word[POS_CH1B +: W_VOLB]; // RL11
            c2a_reg <= word[POS_CH2A +: W_VOLA]; // RL10
            c2b_reg <= word[POS_CH2B +: W_VOLB]; // RL11
        end
    end

    always_ff @(posedge core_clk or negedge rstnCore) begin
        if (!rstnCore) begin
            frameRejected <= 1'b0;
            settingsUpdated <= 1'b0;
        end else begin
            frameRejected <= frameEvent && !csOk; // RL4
            settingsUpdated <= frameEvent && csOk;
        end
    end

    // ---------------------------------------------------------------
    // Field decode; code bits sent first are the field MSB
    // ---------------------------------------------------------------
    function automatic logic [2:0] rev3(input logic [2:0] v);
        rev3 = {v[0], v[1], v[2]};
    endfunction
    function automatic logic [4:0] rev5(input logic [4:0] v);
        rev5 = {v[0], v[1], v[2], v[3], v[4]};
    endfunction
    function automatic logic [1:0] rev2(input logic [1:0] v);
        rev2 = {v[0], v[1]};
    endfunction

    // Coarse code: 0..21 in 2dB steps, 22..30 from 46dB in 4dB steps
    function automatic logic [6:0] coarseDb(input logic [4:0] c);
        logic [6:0] cw;
        cw = {2'h0, c};
        if (c <= VOLA_42DB) begin
            coarseDb = 7'(cw << 1); // RL10
        end else begin
            coarseDb = 7'((cw << 2) - ({2'h0, VOLA_42DB} << 1)); // RL10
        end
    endfunction

    // Fine -2/-3 only take hold at coarse 42dB or deeper; else capped at 1
    function automatic logic [6:0] totalDb(input logic [4:0] c, input logic [1:0] f);
        logic [1:0] fEff;
        fEff = (c < VOLA_42DB && f > VOLB_1DB) ? VOLB_1DB : f; // RL12
        totalDb = 7'(coarseDb(c) + {5'h00, fEff}); // RL12
    endfunction

    always_ff @(posedge core_clk or negedge rstnCore) begin
        if (!rstnCore) begin
            gainSel11dB <= RST_GAIN;
            dynBassCode <= RST_DBB;
            bassBoost <= 1'b0;
            bassMag <= 3'h0;
            trebBoost <= 1'b0;
            trebMag <= 3'h0;
            ch1Coarse <= RST_VOLA;
            ch1Fine <= RST_VOLB;
            ch2Coarse <= RST_VOLA;
            ch2Fine <= RST_VOLB;
            ch1Mute <= 1'b1;
            ch2Mute <= 1'b1;
            ch1AttenDb <= 7'h00;
            ch2AttenDb <= 7'h00;
        end else begin
            gainSel11dB <= gain_reg; // RL6
            dynBassCode <= rev3(dbb_reg); // RL7
            bassBoost <= bass_reg[0]; // RL8
            bassMag <= rev3(bass_reg[3:1]); // RL8
            trebBoost <= treb_reg[0]; // RL9
            trebMag <= rev3(treb_reg[3:1]); // RL9
            ch1Coarse <= rev5(c1a_reg);
            ch1Fine <= rev2(c1b_reg);
            ch2Coarse <= rev5(c2a_reg);
            ch2Fine <= rev2(c2b_reg);
            ch1Mute <= (rev5(c1a_reg) == VOLA_MUTE); // RL10
            ch2Mute <= (rev5(c2a_reg) == VOLA_MUTE); // RL10
            ch1AttenDb <= totalDb(rev5(c1a_reg), rev2(c1b_reg)); // RL11
            ch2AttenDb <= totalDb(rev5(c2a_reg), rev2(c2b_reg)); // RL11
        end
    end
endmodule
`default_nettype wire
